// File: core/pev_defines.svh
// Constants for the parallel program/verify access block.
// Assumes inclusion by bare name from core/.
`ifndef PEV_DEFINES_SVH
`define PEV_DEFINES_SVH
// Mode codes on the mode code port.
`define PEV_CODE_PROG_CODE   8'h68
`define PEV_CODE_PROG_CFG    8'h69
`define PEV_CODE_PROG_LOCK   8'h6B
`define PEV_CODE_PROG_KEY    8'h6C
`define PEV_CODE_VER_CODE    8'h28
`define PEV_CODE_VER_CFG     8'h29
`define PEV_CODE_VER_LOCK    8'h2B
// Addresses.
`define PEV_ADDR_CFG_FIRST   16'hFFF8
`define PEV_ADDR_CFG_SECOND  16'hFFF9
`define PEV_ADDR_LOCK_ZERO   16'h0001
`define PEV_ADDR_LOCK_ONE    16'h0002
`define PEV_ADDR_LOCK_TWO    16'h0003
`define PEV_ADDR_LOCK_READ   16'h0000
`define PEV_ADDR_SIG_0       16'h0030
`define PEV_ADDR_SIG_1       16'h0031
`define PEV_ADDR_SIG_2       16'h0060
`define PEV_ADDR_SIG_3       16'h0061
`define PEV_CODE_SPACE_MAX   16'h7FFF
`define PEV_KEY_SPACE_MAX    16'h007F
// Erased value and settle count.
`define PEV_ERASED_BYTE      8'hFF
`define PEV_ERASED_LOCK      3'h0
`define PEV_SETUP_CYCLES     2
`endif

// File: core/pev_pkg.sv
// Types shared by the program/verify block.
// Assumes pev_defines.svh is on the include path.
package pev_pkg;
  typedef enum logic [1:0] {
    PEV_IDLE  = 2'b00,
    PEV_SETUP = 2'b01,
    PEV_ARMED = 2'b10
  } pev_state_t;

  typedef enum logic [2:0] {
    PEV_OP_NONE   = 3'b000,
    PEV_OP_P_CODE = 3'b001,
    PEV_OP_P_CFG  = 3'b010,
    PEV_OP_P_LOCK = 3'b011,
    PEV_OP_P_KEY  = 3'b100,
    PEV_OP_V_CODE = 3'b101,
    PEV_OP_V_CFG  = 3'b110,
    PEV_OP_V_LOCK = 3'b111
  } pev_op_t;
endpackage : pev_pkg

// File: core/pev_mem.sv
// Flip-flop byte store with one write port and one read port.
// Assumes a single clock and synchronous active-low reset to erased.
`timescale 1ns/1ps
`include "pev_defines.svh"
module pev_mem #(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // Clock and reset.
  input  wire logic          clock_i,
  input  wire logic          reset_n_i,
  // Write port.
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  // Read port.
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [7:0]    rd_data_o
);
  logic [7:0] cells [DEPTH];

  // One-time programmable cells only clear bits; erased is all ones.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        cells[i] <= `PEV_ERASED_BYTE;
      end
    end else if (wr_en_i) begin
      cells[wr_addr_i] <= cells[wr_addr_i] & wr_data_i;
    end
  end

  assign rd_data_o = cells[rd_addr_i];
endmodule : pev_mem

// File: core/pev_lock.sv
// Lock bit store and security level decode.
// Assumes the caller gates writes with the programming permission.
`timescale 1ns/1ps
`include "pev_defines.svh"
module pev_lock (
  // Clock and reset.
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Programming.
  input  wire logic       set_en_i,
  input  wire logic [1:0] set_idx_i,
  // Level decode.
  output logic      [2:0] lock_level_field_o,
  output logic            prog_block_o,
  output logic            verify_block_o,
  output logic            ext_exec_block_o
);
  logic [2:0] lock_bits;

  // A lock bit once set stays set; only the block reset clears it back to erased.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      lock_bits <= `PEV_ERASED_LOCK;
    end else if (set_en_i) begin
      lock_bits[set_idx_i] <= 1'b1;
    end
  end

  // Higher levels imply all lower restrictions.
  assign lock_level_field_o = lock_bits;
  assign prog_block_o       = |lock_bits;
  assign verify_block_o     = |lock_bits[2:1];
  assign ext_exec_block_o   = lock_bits[2];
endmodule : pev_lock

// File: core/pev_top.sv
// Parallel program/verify access to the on-chip non-volatile areas.
// Assumes the programmer drives pins synchronous to clock_i; reset_n_i is the
// block's own reset, device_reset_i is the programming-mode reset pin level.
`timescale 1ns/1ps
`include "pev_defines.svh"

// Contract
// - Address high byte on address high port, low byte on low port.
// - Program and verify operations may interleave in one sequence.
// - Code 68h programs code memory in the 32 KB range.
// - Code 69h programs configuration bytes at FFF8h and FFF9h.
// - Code 6Bh programs lock bits at 0001h to 0003h, data ignored.
// - Code 6Ch programs the 128-byte key array at 0000h-007Fh.
// - Verify drives the selected byte on the data port.
// - Code 28h verifies code memory over 32 KB.
// - Code 29h reads configuration bytes and signature bytes.
// - The key array can never be read out.
// - Signature bytes cannot be written.
// - Code verify XNORs data with key byte at low seven address bits.
// - Lock bits set levels blocking program, verify, external execution.
module pev_top
  import pev_pkg::*;
#(
  parameter int        CODE_DEPTH = 32768,
  parameter int        KEY_DEPTH  = 128,
  parameter logic [7:0] SIG_VENDOR = 8'hA5, // Arbitrary identity value.
  parameter logic [7:0] SIG_ARCH   = 8'h5A, // Arbitrary identity value.
  parameter logic [7:0] SIG_MEMORY = 8'h3C, // Arbitrary identity value.
  parameter logic [7:0] SIG_REV    = 8'hC3  // Arbitrary identity value.
) (
  // Clock and block reset.
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  // Programming pins.
  input  wire logic         device_reset_i,
  input  wire logic         fetch_strobe_n_i,
  input  wire logic         latch_program_pulse_n_i,
  input  wire logic         access_select_prog_voltage_i,
  input  wire logic [7:0]   mode_code_port_i,
  input  wire logic [7:0]   address_high_port_i,
  input  wire logic [7:0]   address_low_port_i,
  // Data port, three signals.
  input  wire logic [7:0]   data_port_i,
  output logic      [7:0]   data_port_o,
  output logic              data_port_oe_o,
  // Status.
  output logic              prog_mode_o,
  output logic [2:0]        lock_level_field_o,
  output logic              ext_exec_block_o
);
  import pev_pkg::*;

  // ----------------------------------------------------------------------
  // Mode entry
  // ----------------------------------------------------------------------
  pev_state_t state;
  logic [1:0] setup_cnt;
  logic       armed;
  assign armed = (state == PEV_ARMED);

  // Control lines must be high for the settle count before the strobe falls;
  // an early fall is not honoured, so a sloppy programmer never writes.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state     <= PEV_IDLE;
      setup_cnt <= 2'h0;
    end else if (!device_reset_i) begin
      state     <= PEV_IDLE;
      setup_cnt <= 2'h0;
    end else begin
      case (state)
        PEV_IDLE: begin
          if (fetch_strobe_n_i && latch_program_pulse_n_i && &mode_code_port_i) begin
            state     <= PEV_SETUP;
            setup_cnt <= 2'h1;
          end
        end
        PEV_SETUP: begin
          if (!fetch_strobe_n_i) begin
            state <= (setup_cnt >= 2'(`PEV_SETUP_CYCLES)) ? PEV_ARMED : PEV_IDLE;
          end else if (setup_cnt < 2'(`PEV_SETUP_CYCLES)) begin
            setup_cnt <= setup_cnt + 2'h1;
          end
        end
        PEV_ARMED: begin
          if (fetch_strobe_n_i) begin
            state <= PEV_IDLE;
          end
        end
        default: state <= PEV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------------
  function automatic pev_op_t decode_op(input logic [7:0] code);
    case (code)
      `PEV_CODE_PROG_CODE: decode_op = PEV_OP_P_CODE;
      `PEV_CODE_PROG_CFG:  decode_op = PEV_OP_P_CFG;
      `PEV_CODE_PROG_LOCK: decode_op = PEV_OP_P_LOCK;
      `PEV_CODE_PROG_KEY:  decode_op = PEV_OP_P_KEY;
      `PEV_CODE_VER_CODE:  decode_op = PEV_OP_V_CODE;
      `PEV_CODE_VER_CFG:   decode_op = PEV_OP_V_CFG;
      `PEV_CODE_VER_LOCK:  decode_op = PEV_OP_V_LOCK;
      default:             decode_op = PEV_OP_NONE;
    endcase
  endfunction : decode_op

  pev_op_t     op;
  logic [15:0] addr;
  logic        pulse_d;
  logic        prog_fire;
  logic        prog_block;
  logic        verify_block;

  assign op   = armed ? decode_op(mode_code_port_i) : PEV_OP_NONE;
  assign addr = {address_high_port_i, address_low_port_i};

  // Falling edge of the pulse line under high voltage writes exactly once.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pulse_d <= 1'b1;
    end else begin
      pulse_d <= latch_program_pulse_n_i;
    end
  end
  assign prog_fire = armed && access_select_prog_voltage_i && pulse_d && !latch_program_pulse_n_i;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic       code_wr;
  logic       key_wr;
  logic       lock_wr;
  logic [7:0] code_rd;
  logic [7:0] key_rd;
  logic [7:0] cfg_first;
  logic [7:0] cfg_second;

  // Level 1 and up block code, config and key writes; lock writes still go.
  assign code_wr = prog_fire && (op == PEV_OP_P_CODE) && !prog_block && (addr <= `PEV_CODE_SPACE_MAX);
  assign key_wr  = prog_fire && (op == PEV_OP_P_KEY) && !prog_block && (addr <= `PEV_KEY_SPACE_MAX);
  assign lock_wr = prog_fire && (op == PEV_OP_P_LOCK) &&
                   (addr >= `PEV_ADDR_LOCK_ZERO) && (addr <= `PEV_ADDR_LOCK_TWO);

  pev_mem #(.DEPTH(CODE_DEPTH), .AW(15)) u_code (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (code_wr),
    .wr_addr_i (addr[14:0]),
    .wr_data_i (data_port_i),
    .rd_addr_i (addr[14:0]),
    .rd_data_o (code_rd)
  );

  pev_mem #(.DEPTH(KEY_DEPTH), .AW(7)) u_key (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (key_wr),
    .wr_addr_i (addr[6:0]),
    .wr_data_i (data_port_i),
    .rd_addr_i (addr[6:0]),
    .rd_data_o (key_rd)
  );

  pev_lock u_lock (
    .clock_i            (clock_i),
    .reset_n_i          (reset_n_i),
    .set_en_i           (lock_wr),
    .set_idx_i          (2'(addr[1:0] - 2'h1)),
    .lock_level_field_o (lock_level_field_o),
    .prog_block_o       (prog_block),
    .verify_block_o     (verify_block),
    .ext_exec_block_o   ()
  );

  // Configuration bytes; signature bytes are constants with no write path.
  // Only the two exact configuration addresses match, so a signature never does.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cfg_first  <= `PEV_ERASED_BYTE;
      cfg_second <= `PEV_ERASED_BYTE;
    end else if (prog_fire && (op == PEV_OP_P_CFG) && !prog_block) begin
      if (addr == `PEV_ADDR_CFG_FIRST) begin
        cfg_first <= cfg_first & data_port_i;
      end
      if (addr == `PEV_ADDR_CFG_SECOND) begin
        cfg_second <= cfg_second & data_port_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Verify read path
  // ----------------------------------------------------------------------
  logic [7:0] next_rd;
  logic       next_oe;

  // Reads need normal voltage and the pulse line high; the key array has no
  // read selection at all, so it cannot leak except as XNOR mixing.
  always_comb begin
    next_rd = 8'h00;
    next_oe = 1'b0;
    if (!access_select_prog_voltage_i && latch_program_pulse_n_i) begin
      case (op)
        PEV_OP_V_CODE: begin
          next_oe = 1'b1;
          next_rd = verify_block ? 8'hFF : ~(code_rd ^ key_rd);
        end
        PEV_OP_V_CFG: begin
          next_oe = 1'b1;
          case (addr)
            `PEV_ADDR_CFG_FIRST:  next_rd = cfg_first;
            `PEV_ADDR_CFG_SECOND: next_rd = cfg_second;
            `PEV_ADDR_SIG_0:      next_rd = SIG_VENDOR;
            `PEV_ADDR_SIG_1:      next_rd = SIG_ARCH;
            `PEV_ADDR_SIG_2:      next_rd = SIG_MEMORY;
            `PEV_ADDR_SIG_3:      next_rd = SIG_REV;
            default:              next_rd = 8'hFF;
          endcase
        end
        PEV_OP_V_LOCK: begin
          next_oe = (addr == `PEV_ADDR_LOCK_READ);
          next_rd = {5'h00, lock_level_field_o};
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  // Registered outputs keep the pins glitch free.
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      data_port_o      <= 8'h00;
      data_port_oe_o   <= 1'b0;
      prog_mode_o      <= 1'b0;
      ext_exec_block_o <= 1'b0;
    end else begin
      data_port_o      <= next_rd;
      data_port_oe_o   <= next_oe;
      prog_mode_o      <= armed;
      ext_exec_block_o <= lock_level_field_o[2];
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  chk_no_drive_idle: assert property (!armed |=> !data_port_oe_o)
    else $error("Data port driven outside programming mode.");
  chk_unknown_code: assert property (armed && decode_op(mode_code_port_i) == PEV_OP_NONE |=> !data_port_oe_o)
    else $error("Data port driven for an unknown code.");
  chk_code_xnor: assert property (op == PEV_OP_V_CODE && next_oe && !verify_block
                                  |=> data_port_o == ~($past(code_rd) ^ $past(key_rd)))
    else $error("Code verify data not key mixed.");
  chk_verify_lock: assert property (op == PEV_OP_V_CODE && verify_block |=> data_port_o == 8'hFF)
    else $error("Locked code memory leaked.");
  chk_prog_lock: assert property (prog_block |-> !code_wr && !key_wr)
    else $error("Write allowed at locked level.");
  chk_one_write: assert property (prog_fire |=> !prog_fire)
    else $error("Single pulse wrote twice.");
  chk_setup_time: assert property (state == PEV_IDLE ##1 (state == PEV_SETUP && !fetch_strobe_n_i)
                                   |=> state == PEV_IDLE)
    else $error("Strobe accepted before two setup cycles.");
  chk_exit_reset: assert property (!device_reset_i |=> state == PEV_IDLE)
    else $error("Mode held without device reset.");
  chk_lock_read: assert property (op == PEV_OP_V_LOCK && next_oe
                                  |=> data_port_o[2:0] == $past(lock_level_field_o))
    else $error("Lock byte read wrong.");
  // Read side guards: a raised voltage or a low pulse line never lets the pins drive.
  chk_read_normal: assert property (access_select_prog_voltage_i || !latch_program_pulse_n_i |=> !data_port_oe_o)
    else $error("Data port driven during a write.");
  chk_key_hidden: assert property (op == PEV_OP_P_KEY |=> !data_port_oe_o)
    else $error("Key array code drove the data port.");
  chk_cfg_locked: assert property (prog_block |=> cfg_first == $past(cfg_first) && cfg_second == $past(cfg_second))
    else $error("Configuration byte changed while locked.");

  // Main scenarios that the bench should reach at least once.
  cov_armed: cover property (state == PEV_SETUP ##1 armed);
  cov_program: cover property (code_wr);
  cov_verify: cover property (op == PEV_OP_V_CODE && next_oe);
  cov_sig: cover property (op == PEV_OP_V_CFG && addr == `PEV_ADDR_SIG_0);
endmodule : pev_top

// File: verif/pev_prog_model.sv
// Behavioural parallel programmer driving the program/verify pins.
// Assumes one clock shared with the device; the bench calls its tasks.
`timescale 1ns/1ps
module pev_prog_model (
  // Clock.
  input  wire logic       clock_i,
  // Pins towards the device.
  output logic            device_reset_o,
  output logic            fetch_strobe_n_o,
  output logic            latch_program_pulse_n_o,
  output logic            access_select_prog_voltage_o,
  output logic [7:0]      mode_code_port_o,
  output logic [7:0]      address_high_port_o,
  output logic [7:0]      address_low_port_o,
  output logic [7:0]      data_port_o,
  // Read side from the device.
  input  wire logic [7:0] data_port_i,
  input  wire logic       data_port_oe_i
);
  // ------------------------------
  // Sequence entry and exit
  // ------------------------------
  // Pins start released so nothing happens before the bench asks.
  initial begin
    {device_reset_o, access_select_prog_voltage_o} = 2'b00;
    {fetch_strobe_n_o, latch_program_pulse_n_o} = 2'b11;
    {mode_code_port_o, address_high_port_o, address_low_port_o, data_port_o} = 32'hFFFF_FFFF;
  end

  // Controls go high first; the strobe drops after hold edges, so a hold of
  // one gives a deliberately early drop that the device must refuse.
  task automatic enter_seq(input int hold);
    @(posedge clock_i);
    device_reset_o          <= 1'b1;
    fetch_strobe_n_o        <= 1'b1;
    latch_program_pulse_n_o <= 1'b1;
    mode_code_port_o        <= 8'hFF;
    repeat (hold) @(posedge clock_i);
    fetch_strobe_n_o <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : enter_seq

  // Releasing strobe, mode code and device reset ends the sequence.
  task automatic leave_seq();
    @(posedge clock_i);
    fetch_strobe_n_o <= 1'b1;
    mode_code_port_o <= 8'hFF;
    device_reset_o   <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : leave_seq

  // ------------------------------
  // Operations
  // ------------------------------
  // Code and address are held until the voltage is back at normal supply.
  task automatic program_byte(input logic [7:0] code, input logic [15:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    mode_code_port_o             <= code;
    address_high_port_o          <= addr[15:8];
    address_low_port_o           <= addr[7:0];
    data_port_o                  <= data;
    access_select_prog_voltage_o <= 1'b1;
    @(posedge clock_i);
    latch_program_pulse_n_o <= 1'b0;
    @(posedge clock_i);
    latch_program_pulse_n_o <= 1'b1;
    @(posedge clock_i);
    access_select_prog_voltage_o <= 1'b0;
    data_port_o                  <= ~data;
    repeat (2) @(posedge clock_i);
  endtask : program_byte

  // The write data lines are let go; they show the inverse of the last value.
  task automatic verify_byte(input logic [7:0] code, input logic [15:0] addr, input logic vpp,
                             output logic [7:0] q, output logic oe);
    @(posedge clock_i);
    mode_code_port_o             <= code;
    address_high_port_o          <= addr[15:8];
    address_low_port_o           <= addr[7:0];
    access_select_prog_voltage_o <= vpp;
    latch_program_pulse_n_o      <= 1'b1;
    data_port_o                  <= ~data_port_o;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    q  = data_port_i;
    oe = data_port_oe_i;
  endtask : verify_byte
endmodule : pev_prog_model

// File: verif/test_pev_top.sv
// Self-checking bench for the parallel program/verify block.
// Assumes pev_pkg and pev_defines.svh from core/ and the programmer model.
`timescale 1ns/1ps
module test_pev_top;
  import pev_pkg::*;
  // ------------------------------
  // Signals and instances
  // ------------------------------
  localparam logic [7:0]  SIG_VAL [4] = '{8'h1E, 8'h2D, 8'h4B, 8'h87}; // Arbitrary identity values.
  localparam logic [15:0] SIG_ADR [4] = '{16'h0030, 16'h0031, 16'h0060, 16'h0061};
  logic       clock_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic       dev_rst, strobe_n, pulse_n, vpp, data_oe, prog_mode, ext_block;
  logic [7:0] code, addr_hi, addr_lo, wdata, rdata;
  logic [2:0] lock_field;
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycle_count = 0;

  pev_top #(.SIG_VENDOR(SIG_VAL[0]), .SIG_ARCH(SIG_VAL[1]), .SIG_MEMORY(SIG_VAL[2]), .SIG_REV(SIG_VAL[3])) pev_top_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .device_reset_i(dev_rst), .fetch_strobe_n_i(strobe_n),
    .latch_program_pulse_n_i(pulse_n), .access_select_prog_voltage_i(vpp), .mode_code_port_i(code),
    .address_high_port_i(addr_hi), .address_low_port_i(addr_lo), .data_port_i(wdata), .data_port_o(rdata),
    .data_port_oe_o(data_oe), .prog_mode_o(prog_mode), .lock_level_field_o(lock_field),
    .ext_exec_block_o(ext_block));

  pev_prog_model pev_prog_model_i (
    .clock_i(clock_i), .device_reset_o(dev_rst), .fetch_strobe_n_o(strobe_n), .latch_program_pulse_n_o(pulse_n),
    .access_select_prog_voltage_o(vpp), .mode_code_port_o(code), .address_high_port_o(addr_hi),
    .address_low_port_o(addr_lo), .data_port_o(wdata), .data_port_i(rdata), .data_port_oe_i(data_oe));

  // ------------------------------
  // Clock, timeout and helpers
  // ------------------------------
  // A 50 ns period; the ceiling is well above the roughly 220 cycles needed.
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: run did not finish in time", $time);
      final_report();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Read data is only compared when the device is expected to drive.
  task automatic vchk(input logic [7:0] c, input logic [15:0] a, input logic v, input logic eoe, input logic [7:0] eq);
    logic [7:0] q;
    logic       oe;
    pev_prog_model_i.verify_byte(c, a, v, q, oe);
    check({7'h00, oe}, {7'h00, eoe}, "drive enable");
    if (eoe) check(q, eq, "read data");
  endtask : vchk

  task automatic prog(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    pev_prog_model_i.program_byte(c, a, d);
  endtask : prog

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    repeat (12) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(negedge clock_i);
    check({2'b00, lock_field, prog_mode, ext_block, data_oe}, 8'h00, "status after reset");
    vchk(8'h28, 16'h0000, 1'b0, 1'b0, 8'h00);
    pev_prog_model_i.enter_seq(1);
    check({7'h00, prog_mode}, 8'h00, "early strobe refused");
    vchk(8'h28, 16'h0000, 1'b0, 1'b0, 8'h00);
    pev_prog_model_i.leave_seq();
    pev_prog_model_i.enter_seq(3);
    check({7'h00, prog_mode}, 8'h01, "programming mode");
    $display("test reset_and_entry done");
    // Code memory, interleaved with verifies and with one verify under raised voltage.
    vchk(8'h28, 16'h7FFF, 1'b0, 1'b1, 8'hFF);
    prog(8'h68, 16'h7FFF, 8'h3C);
    vchk(8'h28, 16'h7FFF, 1'b0, 1'b1, 8'h3C);
    prog(8'h68, 16'h0100, 8'hA5);
    vchk(8'h28, 16'h0100, 1'b0, 1'b1, 8'hA5);
    vchk(8'h28, 16'h0001, 1'b0, 1'b1, 8'hFF);
    vchk(8'h28, 16'h0100, 1'b1, 1'b0, 8'h00);
    $display("test code_memory done");
    // Configuration and signature bytes; a write aimed at a signature is lost.
    prog(8'h69, 16'hFFF8, 8'h12);
    prog(8'h69, 16'hFFF9, 8'h34);
    prog(8'h69, 16'h0030, 8'h00);
    vchk(8'h29, 16'hFFF8, 1'b0, 1'b1, 8'h12);
    vchk(8'h29, 16'hFFF9, 1'b0, 1'b1, 8'h34);
    for (int i = 0; i < 4; i++) begin
      vchk(8'h29, SIG_ADR[i], 1'b0, 1'b1, SIG_VAL[i]);
    end
    $display("test config_signature done");
    // Key bytes scramble code reads at both ends of the key range.
    prog(8'h6C, 16'h0000, 8'h0F);
    prog(8'h6C, 16'h007F, 8'hF0);
    vchk(8'h28, 16'h0100, 1'b0, 1'b1, 8'h55);
    vchk(8'h28, 16'h7FFF, 1'b0, 1'b1, 8'h33);
    vchk(8'h6C, 16'h0000, 1'b0, 1'b0, 8'h00);
    prog(8'h55, 16'h0100, 8'h00);
    vchk(8'h55, 16'h0100, 1'b0, 1'b0, 8'h00);
    vchk(8'h28, 16'h0100, 1'b0, 1'b1, 8'h55);
    $display("test encryption_unknown done");
    // Lock levels raised one at a time, each blocking more.
    vchk(8'h2B, 16'h0000, 1'b0, 1'b1, 8'h00);
    vchk(8'h2B, 16'h0001, 1'b0, 1'b0, 8'h00);
    prog(8'h6B, 16'h0001, 8'hA5);
    check({5'h00, lock_field}, 8'h01, "lock level one");
    vchk(8'h2B, 16'h0000, 1'b0, 1'b1, 8'h01);
    prog(8'h68, 16'h0002, 8'h00);
    prog(8'h69, 16'hFFF8, 8'h00);
    vchk(8'h28, 16'h0002, 1'b0, 1'b1, 8'hFF);
    vchk(8'h29, 16'hFFF8, 1'b0, 1'b1, 8'h12);
    prog(8'h6B, 16'h0002, 8'h00);
    vchk(8'h28, 16'h0100, 1'b0, 1'b1, 8'hFF);
    vchk(8'h2B, 16'h0000, 1'b0, 1'b1, 8'h03);
    prog(8'h6B, 16'h0003, 8'h00);
    check({4'h0, ext_block, lock_field}, 8'h0F, "lock level three");
    vchk(8'h29, 16'hFFF9, 1'b0, 1'b1, 8'h34);
    $display("test lock_levels done");
    // After release the ports are ordinary pins again.
    pev_prog_model_i.leave_seq();
    check({7'h00, prog_mode}, 8'h00, "mode after release");
    vchk(8'h29, 16'hFFF8, 1'b0, 1'b0, 8'h00);
    $display("test release done");
    final_report();
  end
endmodule : test_pev_top
